// File: core/tsrf_pkg.sv
// package: register map, field positions and carrier types of the status block
`default_nettype none
package tsrf_pkg;
  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam int TSRF_ADDR_W = 10;
  localparam logic [7:0] TSRF_IDX_STATUS_CTRL = 8'h6E;
  localparam logic [7:0] TSRF_IDX_ALARM_PRI = 8'h70;
  localparam logic [7:0] TSRF_IDX_ALARM_RXP = 8'h71;
  localparam logic [7:0] TSRF_IDX_WARN_PRI = 8'h74;
  localparam logic [7:0] TSRF_IDX_WARN_RXP = 8'h75;
  localparam logic [7:0] TSRF_IDX_EXT_CTRL = 8'h76;
  localparam logic [7:0] TSRF_IDX_IRQ_STATUS = 8'h80;
  localparam logic [7:0] TSRF_IDX_IRQ_MASK = 8'h81;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TSRF_SC_TXDIS_PIN = 7;
  localparam int TSRF_SC_SOFT_TXDIS = 6;
  localparam int TSRF_SC_TX_RATE_PIN = 5;
  localparam int TSRF_SC_RX_RATE_PIN = 4;
  localparam int TSRF_SC_SOFT_RX_RATE = 3;
  localparam int TSRF_SC_TX_FAULT = 2;
  localparam int TSRF_SC_RX_LOS = 1;
  localparam int TSRF_SC_READY_N = 0;
  localparam int TSRF_EXT_SOFT_TX_RATE = 3;
  localparam int TSRF_FL_TEMP_HI = 7;
  localparam int TSRF_FL_TEMP_LO = 6;
  localparam int TSRF_FL_VCC_HI = 5;
  localparam int TSRF_FL_VCC_LO = 4;
  localparam int TSRF_FL_BIAS_HI = 3;
  localparam int TSRF_FL_BIAS_LO = 2;
  localparam int TSRF_FL_TXP_HI = 1;
  localparam int TSRF_FL_TXP_LO = 0;
  localparam int TSRF_FL_RXP_HI = 7;
  localparam int TSRF_FL_RXP_LO = 6;
  localparam int TSRF_IRQ_ALARM = 0;
  localparam int TSRF_IRQ_WARN = 1;
  localparam int TSRF_IRQ_TX_FAULT = 2;
  localparam int TSRF_IRQ_RX_LOS = 3;
  localparam int TSRF_IRQ_READY = 4;
  localparam int TSRF_IRQ_W = 5;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [7:0] TSRF_FLAGS_RST = 8'h00;
  localparam logic [TSRF_IRQ_W-1:0] TSRF_IRQ_RST = 5'h00;
  localparam logic TSRF_SOFT_BIT_RST = 1'b0;
  localparam logic TSRF_READY_N_RST = 1'b1;
  localparam int TSRF_CLK_HZ = 125_000_000;
  localparam int TSRF_SOFT_RESP_MS = 100;
  // longest allowed response, rounded down; the logic reacts within two cycles
  localparam longint TSRF_SOFT_RESP_CYC =
    longint'(TSRF_CLK_HZ) * TSRF_SOFT_RESP_MS / 1000;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] tx_pwr;
    logic [15:0] rx_pwr;
  } tsrf_meas_t;

  typedef struct packed {
    tsrf_meas_t alarm_hi;
    tsrf_meas_t alarm_lo;
    tsrf_meas_t warn_hi;
    tsrf_meas_t warn_lo;
  } tsrf_limits_t;

  typedef struct packed {
    logic tx_fault;
    logic rx_los;
    logic tx_disable;
    logic rx_rate_select_pin;
    logic tx_rate_select_pin;
  } tsrf_pins_t;

  typedef enum logic [1:0] {
    TSRF_BUS_IDLE = 2'b01,
    TSRF_BUS_ACK = 2'b10
  } tsrf_bus_state_t;
endpackage : tsrf_pkg

`default_nettype wire

// File: core/tsrf_top.sv
// module: transceiver status, soft control, flags and rate select bank
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module tsrf_top
  import tsrf_pkg::*;
(
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic [TSRF_ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // high until request is taken
  output logic irq, // level interrupt
  input wire tsrf_pins_t pins, // module pin levels
  input wire logic mon_update, // one-cycle pulse: new monitor sample
  input wire tsrf_meas_t meas, // monitored values
  input wire tsrf_limits_t limits, // alarm and warning limits
  output logic tx_disable_out, // transmitter disable, active high
  output logic rx_rate_full, // 1 = full rate receive
  output logic tx_rate_full // 1 = full rate transmit
);

  // ****************************************************************
  // bus slave handshake
  // ****************************************************************
  tsrf_bus_state_t bus_state_reg;
  tsrf_bus_state_t bus_state_next;
  logic [7:0] idx;
  logic bus_take;
  logic wr_take;
  logic [31:0] rd_next;

  assign idx = avs_address[TSRF_ADDR_W-1:2];
  // request accepted at the edge where waitrequest is low
  assign bus_take = (bus_state_reg == TSRF_BUS_ACK) &&
    (avs_read || avs_write);
  assign wr_take = bus_take && avs_write && avs_byteenable[0] &&
    (avs_address[1:0] == 2'b00);

  // every grant is followed by an idle state, so a request still held
  // at the granting edge is never taken a second time
  always_comb begin
    case (bus_state_reg)
      TSRF_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_state_next = TSRF_BUS_ACK;
        end else begin
          bus_state_next = TSRF_BUS_IDLE;
        end
      end
      TSRF_BUS_ACK: bus_state_next = TSRF_BUS_IDLE;
      default: bus_state_next = TSRF_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state_reg <= TSRF_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      bus_state_reg <= bus_state_next;
      avs_waitrequest <= (bus_state_next != TSRF_BUS_ACK);
    end
  end

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  // one stage: status mirrors lag the pins by a cycle, outputs by two
  tsrf_pins_t pins_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pins;
    end
  end

  // ****************************************************************
  // soft control bits
  // ****************************************************************
  // lane 0 off or a misaligned address leaves these bits unchanged
  logic soft_txdis_reg;
  logic soft_rx_rate_reg;
  logic soft_tx_rate_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      soft_txdis_reg <= TSRF_SOFT_BIT_RST;
      soft_rx_rate_reg <= TSRF_SOFT_BIT_RST;
      soft_tx_rate_reg <= TSRF_SOFT_BIT_RST;
    end else if (wr_take) begin
      if (idx == TSRF_IDX_STATUS_CTRL) begin
        soft_txdis_reg <= avs_writedata[TSRF_SC_SOFT_TXDIS];
        soft_rx_rate_reg <= avs_writedata[TSRF_SC_SOFT_RX_RATE];
      end
      if (idx == TSRF_IDX_EXT_CTRL) begin
        soft_tx_rate_reg <= avs_writedata[TSRF_EXT_SOFT_TX_RATE];
      end
    end
  end

  // ****************************************************************
  // effective control outputs
  // ****************************************************************
  // one cycle after the write is taken, two after a pin change, far inside the response limit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      // transmitter held off while reset is applied
      tx_disable_out <= 1'b1;
      rx_rate_full <= 1'b0;
      tx_rate_full <= 1'b0;
    end else begin
      tx_disable_out <= pins_reg.tx_disable | soft_txdis_reg;
      rx_rate_full <= pins_reg.rx_rate_select_pin |
        soft_rx_rate_reg;
      tx_rate_full <= pins_reg.tx_rate_select_pin |
        soft_tx_rate_reg;
    end
  end

  // ****************************************************************
  // monitor flags
  // ****************************************************************
  logic ready_n_reg;
  logic [7:0] alarm_pri_reg;
  logic [7:0] alarm_rxp_reg;
  logic [7:0] warn_pri_reg;
  logic [7:0] warn_rxp_reg;
  logic [7:0] alarm_pri_next;
  logic [7:0] alarm_rxp_next;
  logic [7:0] warn_pri_next;
  logic [7:0] warn_rxp_next;

  // {high, low}; temperature is signed, the other quantities unsigned
  function automatic logic [1:0] tsrf_cmp(
    input logic [15:0] v,
    input logic [15:0] hi,
    input logic [15:0] lo,
    input logic sgn
  );
    logic gt;
    logic lt;
    if (sgn) begin
      gt = $signed(v) > $signed(hi);
      lt = $signed(v) < $signed(lo);
    end else begin
      gt = v > hi;
      lt = v < lo;
    end
    return {gt, lt};
  endfunction : tsrf_cmp

  // ****************************************************************
  // threshold comparisons, each a {high, low} pair
  // ****************************************************************
  logic [1:0] temp_alarm;
  logic [1:0] vcc_alarm;
  logic [1:0] bias_alarm;
  logic [1:0] txp_alarm;
  logic [1:0] rxp_alarm;
  logic [1:0] temp_warn;
  logic [1:0] vcc_warn;
  logic [1:0] bias_warn;
  logic [1:0] txp_warn;
  logic [1:0] rxp_warn;

  // a signed compare would read the upper half of the unsigned
  // quantities as negative, so only temperature takes the signed path
  assign temp_alarm = tsrf_cmp(meas.temp, limits.alarm_hi.temp,
    limits.alarm_lo.temp, 1'b1);
  assign vcc_alarm = tsrf_cmp(meas.vcc, limits.alarm_hi.vcc,
    limits.alarm_lo.vcc, 1'b0);
  assign bias_alarm = tsrf_cmp(meas.bias, limits.alarm_hi.bias,
    limits.alarm_lo.bias, 1'b0);
  assign txp_alarm = tsrf_cmp(meas.tx_pwr, limits.alarm_hi.tx_pwr,
    limits.alarm_lo.tx_pwr, 1'b0);
  assign rxp_alarm = tsrf_cmp(meas.rx_pwr, limits.alarm_hi.rx_pwr,
    limits.alarm_lo.rx_pwr, 1'b0);
  assign temp_warn = tsrf_cmp(meas.temp, limits.warn_hi.temp,
    limits.warn_lo.temp, 1'b1);
  assign vcc_warn = tsrf_cmp(meas.vcc, limits.warn_hi.vcc,
    limits.warn_lo.vcc, 1'b0);
  assign bias_warn = tsrf_cmp(meas.bias, limits.warn_hi.bias,
    limits.warn_lo.bias, 1'b0);
  assign txp_warn = tsrf_cmp(meas.tx_pwr, limits.warn_hi.tx_pwr,
    limits.warn_lo.tx_pwr, 1'b0);
  assign rxp_warn = tsrf_cmp(meas.rx_pwr, limits.warn_hi.rx_pwr,
    limits.warn_lo.rx_pwr, 1'b0);

  // reserved bits are never assigned and read as zero
  always_comb begin
    alarm_pri_next = 8'h00;
    alarm_pri_next[TSRF_FL_TEMP_HI] = temp_alarm[1];
    alarm_pri_next[TSRF_FL_TEMP_LO] = temp_alarm[0];
    alarm_pri_next[TSRF_FL_VCC_HI] = vcc_alarm[1];
    alarm_pri_next[TSRF_FL_VCC_LO] = vcc_alarm[0];
    alarm_pri_next[TSRF_FL_BIAS_HI] = bias_alarm[1];
    alarm_pri_next[TSRF_FL_BIAS_LO] = bias_alarm[0];
    alarm_pri_next[TSRF_FL_TXP_HI] = txp_alarm[1];
    alarm_pri_next[TSRF_FL_TXP_LO] = txp_alarm[0];
    alarm_rxp_next = 8'h00;
    alarm_rxp_next[TSRF_FL_RXP_HI] = rxp_alarm[1];
    alarm_rxp_next[TSRF_FL_RXP_LO] = rxp_alarm[0];
    warn_pri_next = 8'h00;
    warn_pri_next[TSRF_FL_TEMP_HI] = temp_warn[1];
    warn_pri_next[TSRF_FL_TEMP_LO] = temp_warn[0];
    warn_pri_next[TSRF_FL_VCC_HI] = vcc_warn[1];
    warn_pri_next[TSRF_FL_VCC_LO] = vcc_warn[0];
    warn_pri_next[TSRF_FL_BIAS_HI] = bias_warn[1];
    warn_pri_next[TSRF_FL_BIAS_LO] = bias_warn[0];
    warn_pri_next[TSRF_FL_TXP_HI] = txp_warn[1];
    warn_pri_next[TSRF_FL_TXP_LO] = txp_warn[0];
    warn_rxp_next = 8'h00;
    warn_rxp_next[TSRF_FL_RXP_HI] = rxp_warn[1];
    warn_rxp_next[TSRF_FL_RXP_LO] = rxp_warn[0];
  end

  // flags follow the latest sample, they are not sticky
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_pri_reg <= TSRF_FLAGS_RST;
      alarm_rxp_reg <= TSRF_FLAGS_RST;
      warn_pri_reg <= TSRF_FLAGS_RST;
      warn_rxp_reg <= TSRF_FLAGS_RST;
    end else if (mon_update) begin
      alarm_pri_reg <= alarm_pri_next;
      alarm_rxp_reg <= alarm_rxp_next;
      warn_pri_reg <= warn_pri_next;
      warn_rxp_reg <= warn_rxp_next;
    end
  end

  // values are not trusted until the first complete sample
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ready_n_reg <= TSRF_READY_N_RST;
    end else if (mon_update) begin
      ready_n_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [TSRF_IRQ_W-1:0] irq_stat_reg;
  logic [TSRF_IRQ_W-1:0] irq_mask_reg;
  logic [TSRF_IRQ_W-1:0] irq_event;
  logic [TSRF_IRQ_W-1:0] irq_clr;
  logic tx_fault_d_reg;
  logic rx_los_d_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_fault_d_reg <= 1'b0;
      rx_los_d_reg <= 1'b0;
    end else begin
      tx_fault_d_reg <= pins_reg.tx_fault;
      rx_los_d_reg <= pins_reg.rx_los;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[TSRF_IRQ_ALARM] = mon_update &&
      (|{alarm_pri_next & ~alarm_pri_reg, alarm_rxp_next & ~alarm_rxp_reg});
    irq_event[TSRF_IRQ_WARN] = mon_update &&
      (|{warn_pri_next & ~warn_pri_reg, warn_rxp_next & ~warn_rxp_reg});
    irq_event[TSRF_IRQ_TX_FAULT] = pins_reg.tx_fault && !tx_fault_d_reg;
    irq_event[TSRF_IRQ_RX_LOS] = pins_reg.rx_los && !rx_los_d_reg;
    irq_event[TSRF_IRQ_READY] = mon_update && ready_n_reg;
    irq_clr = '0;
    if (wr_take && idx == TSRF_IDX_IRQ_STATUS) begin
      irq_clr = avs_writedata[TSRF_IRQ_W-1:0];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_reg <= TSRF_IRQ_RST;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_reg <= TSRF_IRQ_RST;
    end else if (wr_take && idx == TSRF_IDX_IRQ_MASK) begin
      irq_mask_reg <= avs_writedata[TSRF_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[TSRF_SC_TXDIS_PIN] = pins_reg.tx_disable;
    status_byte[TSRF_SC_SOFT_TXDIS] = soft_txdis_reg;
    status_byte[TSRF_SC_TX_RATE_PIN] = pins_reg.tx_rate_select_pin;
    status_byte[TSRF_SC_RX_RATE_PIN] = pins_reg.rx_rate_select_pin;
    status_byte[TSRF_SC_SOFT_RX_RATE] = soft_rx_rate_reg;
    status_byte[TSRF_SC_TX_FAULT] = pins_reg.tx_fault;
    status_byte[TSRF_SC_RX_LOS] = pins_reg.rx_los;
    status_byte[TSRF_SC_READY_N] = ready_n_reg;
  end

  // unmapped or misaligned addresses read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (avs_address[1:0] == 2'b00) begin
      case (idx)
        TSRF_IDX_STATUS_CTRL: rd_next[7:0] = status_byte;
        TSRF_IDX_ALARM_PRI: rd_next[7:0] = alarm_pri_reg;
        TSRF_IDX_ALARM_RXP: rd_next[7:0] = alarm_rxp_reg;
        TSRF_IDX_WARN_PRI: rd_next[7:0] = warn_pri_reg;
        TSRF_IDX_WARN_RXP: rd_next[7:0] = warn_rxp_reg;
        TSRF_IDX_EXT_CTRL: begin
          rd_next[TSRF_EXT_SOFT_TX_RATE] = soft_tx_rate_reg;
        end
        TSRF_IDX_IRQ_STATUS: rd_next[TSRF_IRQ_W-1:0] = irq_stat_reg;
        TSRF_IDX_IRQ_MASK: rd_next[TSRF_IRQ_W-1:0] = irq_mask_reg;
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  // data captured as the slave grants, so it stands at the taking edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_state_reg == TSRF_BUS_IDLE && avs_read) begin
      avs_readdata <= rd_next;
    end
  end

endmodule : tsrf_top

`default_nettype wire

// File: tb/tsrf_properties.sv
// checker: port-level properties of the status, flag and rate bank
`timescale 1ns/1ps
`default_nettype none
module tsrf_properties
  import tsrf_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // async reset
  input wire logic [TSRF_ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // bus stall
  input wire tsrf_pins_t pins, // pin levels
  input wire logic tx_disable_out, // transmitter off
  input wire logic rx_rate_full, // receive full rate
  input wire logic tx_rate_full // transmit full rate
);
  // ****
  // pins settled helper
  // ****
  tsrf_pins_t pins_reg;
  logic [1:0] stab_reg;
  logic st_take;
  logic rxp_take;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg <= '0;
      stab_reg <= 2'h0;
    end else begin
      pins_reg <= pins;
      if (pins != pins_reg) stab_reg <= 2'h0;
      else if (stab_reg != 2'h3) stab_reg <= stab_reg + 2'h1;
    end
  end
  // mirror bits lag the pins, so only judge reads after a quiet spell
  assign st_take = avs_read && !avs_waitrequest && stab_reg == 2'h3 &&
    avs_address == {TSRF_IDX_STATUS_CTRL, 2'h0};
  assign rxp_take = avs_read && !avs_waitrequest &&
    (avs_address == {TSRF_IDX_ALARM_RXP, 2'h0} ||
    avs_address == {TSRF_IDX_WARN_RXP, 2'h0});
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_txdis_pin: assert property (
    pins.tx_disable |-> ##2 tx_disable_out)
    else $error("disable pin did not turn transmitter off");
  chk_rxrate_pin: assert property (
    pins.rx_rate_select_pin |-> ##2 rx_rate_full)
    else $error("receive rate pin did not select full rate");
  chk_txrate_pin: assert property (
    pins.tx_rate_select_pin |-> ##2 tx_rate_full)
    else $error("transmit rate pin did not select full rate");
  chk_fault_mirror: assert property (
    st_take |-> avs_readdata[TSRF_SC_TX_FAULT] == pins.tx_fault)
    else $error("fault bit differs from pin");
  chk_los_mirror: assert property (
    st_take |-> avs_readdata[TSRF_SC_RX_LOS] == pins.rx_los)
    else $error("loss bit differs from pin");
  chk_dis_mirror: assert property (
    st_take |-> avs_readdata[TSRF_SC_TXDIS_PIN] == pins.tx_disable)
    else $error("disable state bit differs from pin");
  chk_rate_mirror: assert property (
    st_take |-> avs_readdata[5:4] ==
    {pins.tx_rate_select_pin, pins.rx_rate_select_pin})
    else $error("rate pin bits differ from pins");
  chk_soft_or: assert property (
    st_take |-> tx_disable_out == (avs_readdata[7] | avs_readdata[6]) &&
    rx_rate_full == (avs_readdata[4] | avs_readdata[3]))
    else $error("output is not pin or soft bit");
  chk_rsvd_zero: assert property (
    rxp_take |-> avs_readdata[31:8] == 24'h0 && avs_readdata[5:0] == 6'h0)
    else $error("reserved flag bits not zero");
endmodule : tsrf_properties

bind tsrf_top tsrf_properties i_tsrf_properties (.clk_sys, .sys_rst,
  .avs_address, .avs_read, .avs_readdata, .avs_waitrequest, .pins,
  .tx_disable_out, .rx_rate_full, .tx_rate_full);
`default_nettype wire

// File: tb/tsrf_host_model.sv
// host model: register-bus master issuing single held transfers
`timescale 1ns/1ps
`default_nettype none
module tsrf_host_model
  import tsrf_pkg::*;
(
  input wire logic clk_sys, // system clock
  output logic [TSRF_ADDR_W-1:0] avs_address, // byte address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_writedata, // write data
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest // stall
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
  end
  // request held until waitrequest is seen low; only the bench bounds it
  task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [3:0] be, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= {idx, 2'h0};
    avs_byteenable <= be;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
endmodule : tsrf_host_model
`default_nettype wire

// File: tb/tsrf_top_tb.sv
// testbench: register, pin, flag and interrupt scenarios for the bank
`timescale 1ns/1ps
`default_nettype none
module tsrf_top_tb;
  import tsrf_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [TSRF_ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq;
  logic mon_update = 1'b0;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic tx_disable_out, rx_rate_full, tx_rate_full;
  tsrf_pins_t pins = '0;
  tsrf_meas_t meas = '0;
  tsrf_limits_t limits = {{5{16'h0400}}, {5{16'h0100}}, {5{16'h0300}},
    {5{16'h0200}}};
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] st_exp [5] = '{8'h21, 8'h11, 8'h81, 8'h03, 8'h05};
  // last sample: temperature below zero, the rest near full scale
  logic [15:0] mval [5] = '{16'h0500, 16'h0080, 16'h0250, 16'h0350,
    16'hFF00};
  logic [7:0] a_exp [5] = '{8'hAA, 8'h55, 8'h00, 8'h00, 8'h6A};
  logic [7:0] w_exp [5] = '{8'hAA, 8'h55, 8'h00, 8'hAA, 8'h6A};

  always #4 clk_sys = ~clk_sys;

  tsrf_top i_tsrf_top (.clk_sys, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .irq, .pins, .mon_update, .meas, .limits,
    .tx_disable_out, .rx_rate_full, .tx_rate_full);
  tsrf_host_model i_tsrf_host_model (.clk_sys, .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest);

  // ****
  // compare, bus and stimulus tasks
  // ****
  task automatic chk_reg(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_pin(input string n, input logic e, g);
    chk_reg(n, {31'h0, e}, {31'h0, g});
  endtask : chk_pin
  task automatic rd(input logic [7:0] idx, e, input string n);
    i_tsrf_host_model.xfer(1'b0, idx, 4'hF, 8'h00, q);
    chk_reg(n, {24'h0, e}, q);
  endtask : rd
  task automatic wr(input logic [7:0] idx, d, input logic [3:0] be = 4'h1);
    i_tsrf_host_model.xfer(1'b1, idx, be, d, q);
  endtask : wr
  task automatic pause;
    repeat (3) @(posedge clk_sys);
  endtask : pause
  task automatic outs(input logic d, r, t);
    pause();
    chk_pin("tx_disable_out", d, tx_disable_out);
    chk_pin("rx_rate_full", r, rx_rate_full);
    chk_pin("tx_rate_full", t, tx_rate_full);
  endtask : outs
  task automatic mon(input logic [15:0] v);
    @(posedge clk_sys);
    meas <= {5{v}};
    mon_update <= 1'b1;
    @(posedge clk_sys);
    mon_update <= 1'b0;
  endtask : mon
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(TSRF_IDX_STATUS_CTRL, 8'h01, "status at reset");
    rd(TSRF_IDX_EXT_CTRL, 8'h00, "ext at reset");
    outs(1'b0, 1'b0, 1'b0);
    rd(8'hFF, 8'h00, "unmapped");
    wr(TSRF_IDX_STATUS_CTRL, 8'h40, 4'h0);
    rd(TSRF_IDX_STATUS_CTRL, 8'h01, "lane off write");
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      pins <= tsrf_pins_t'(5'h01 << k);
      outs(k == 2, k == 1, k == 0);
      rd(TSRF_IDX_STATUS_CTRL, st_exp[k], "pin status");
    end
    @(posedge clk_sys);
    pins <= '0;
    rd(TSRF_IDX_IRQ_STATUS, 8'h0C, "pin events");
    wr(TSRF_IDX_IRQ_STATUS, 8'h0C);
    wr(TSRF_IDX_STATUS_CTRL, 8'hFF);
    outs(1'b1, 1'b1, 1'b0);
    rd(TSRF_IDX_STATUS_CTRL, 8'h49, "soft status");
    wr(TSRF_IDX_EXT_CTRL, 8'hFF);
    rd(TSRF_IDX_EXT_CTRL, 8'h08, "ext ctrl");
    outs(1'b1, 1'b1, 1'b1);
    wr(TSRF_IDX_STATUS_CTRL, 8'h00);
    outs(1'b0, 1'b0, 1'b1);
    wr(TSRF_IDX_EXT_CTRL, 8'h00);
    outs(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      mon(mval[i]);
      rd(TSRF_IDX_ALARM_PRI, a_exp[i], "alarm primary");
      rd(TSRF_IDX_ALARM_RXP, {a_exp[i][1:0], 6'h00}, "alarm rx");
      rd(TSRF_IDX_WARN_PRI, w_exp[i], "warn primary");
      rd(TSRF_IDX_WARN_RXP, {w_exp[i][1:0], 6'h00}, "warn rx");
    end
    rd(TSRF_IDX_STATUS_CTRL, 8'h00, "ready status");
    wr(TSRF_IDX_ALARM_PRI, 8'hFF);
    rd(TSRF_IDX_ALARM_PRI, 8'h6A, "alarm read only");
    rd(TSRF_IDX_IRQ_STATUS, 8'h13, "flag events");
    wr(TSRF_IDX_IRQ_STATUS, 8'h1F);
    rd(TSRF_IDX_IRQ_STATUS, 8'h00, "cleared events");
    wr(TSRF_IDX_IRQ_MASK, 8'h01);
    rd(TSRF_IDX_IRQ_MASK, 8'h01, "mask");
    pause();
    chk_pin("irq idle", 1'b0, irq);
    mon(16'h0500);
    pause();
    chk_pin("irq raised", 1'b1, irq);
    wr(TSRF_IDX_IRQ_STATUS, 8'h01);
    pause();
    chk_pin("irq cleared", 1'b0, irq);
    wr(TSRF_IDX_IRQ_MASK, 8'h00);
    mon(16'h0080);
    pause();
    chk_pin("irq masked", 1'b0, irq);
    rd(TSRF_IDX_IRQ_STATUS, 8'h03, "masked events");
    give_verdict();
  end
endmodule : tsrf_top_tb
`default_nettype wire
